// File: src/gpio_pin_with_disable_lock.sv
// Register access over APB is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_regs.svh"

module gpio_pin_with_disable_lock #(
	parameter int ADDR_W = 12,
	parameter int DISABLE_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic main_rail_por,
	input wire logic standby_rail_por,
	input wire logic hard_reset,
	input wire logic pin_in,
	output logic pin_out,
	output logic pin_oe,
	output logic [DISABLE_W-1:0] device_disable,
	output logic disable_write_lock_control,
	output logic irq
);
	import gpio_pin_pkg::*;

	localparam int IDX_W = ADDR_W - `BYTE_ADDR_SHIFT;

	generate
		if (ADDR_W < 9 || ADDR_W > 32) begin : g_bad_addr
			$error("ADDR_W must be between 9 and 32 to reach every register");
		end
		if (DISABLE_W < 1 || DISABLE_W > 8) begin : g_bad_disable
			$error("DISABLE_W must be between 1 and 8");
		end
		if ($bits(cfg_s) != 8) begin : g_bad_cfg
			$error("configuration layout must fill exactly one byte");
		end
		if (`CFG_ALT_MSB - `CFG_ALT_LSB + 1 != $bits(alt_e)) begin : g_bad_alt
			$error("function field position does not match its type");
		end
		if ((`IRQ_MASK_IDX >> IDX_W) != 0) begin : g_bad_map
			$error("register map does not fit the index width");
		end
	endgenerate

	cfg_s lockable_pin_r;
	cfg_s lockable_pin_nxt;
	logic [7:0] next_port_pin_zero_r;
	logic data_out_r;
	logic [DISABLE_W-1:0] device_disable_r;
	logic [7:0] irq_status_r;
	logic [7:0] irq_mask_r;
	apb_rsp_s rsp_r;
	pin_s pin_r;
	logic lock_r;
	logic irq_r;

	logic setup;
	logic wr_commit;
	logic [IDX_W-1:0] idx;
	logic aligned;
	logic sel_cfg;
	logic sel_next;
	logic sel_data;
	logic sel_dis;
	logic sel_stat;
	logic sel_mask;
	logic mapped;
	logic lane0;
	logic [7:0] wbyte;
	logic lock_mode;
	logic irq_mode;
	logic eff_dir_in;
	logic eff_pol;
	logic pin_value;
	logic pin_edge;
	logic edge_event;
	logic dis_write_try;
	logic dis_write_ok;
	logic drop_event;
	logic [7:0] stat_set;
	logic [7:0] stat_clr;
	logic [31:0] rdata_nxt;
	logic func_clear;
	logic wr_cfg;
	logic wr_next;
	logic wr_data;
	logic wr_stat;
	logic wr_mask;
	logic lock_nxt;
	logic [7:0] irq_status_nxt;
	logic edge_armed_r;
	pin_s pin_nxt;
	apb_rsp_s rsp_nxt;

	// APB decode: the printed offsets are word indices, so the low byte bits must be zero.
	assign setup = psel && !penable;
	assign wr_commit = psel && penable && rsp_r.ready && pwrite;
	assign idx = paddr[ADDR_W-1:`BYTE_ADDR_SHIFT];
	assign aligned = (paddr[`BYTE_ADDR_SHIFT-1:0] == 2'h0);
	assign sel_cfg = aligned && (idx == IDX_W'(`LOCKABLE_PIN_IDX));
	assign sel_next = aligned && (idx == IDX_W'(`NEXT_PORT_PIN_ZERO_IDX));
	assign sel_data = aligned && (idx == IDX_W'(`PIN_DATA_IDX));
	assign sel_dis = aligned && (idx == IDX_W'(`DEVICE_DISABLE_IDX));
	assign sel_stat = aligned && (idx == IDX_W'(`IRQ_STATUS_IDX));
	assign sel_mask = aligned && (idx == IDX_W'(`IRQ_MASK_IDX));
	assign mapped = sel_cfg || sel_next || sel_data || sel_dis || sel_stat || sel_mask;
	// Every register lives in the low byte lane, so only strobe bit 0 matters.
	assign lane0 = pstrb[0];
	assign wbyte = pwdata[7:0];

	// One write enable per register keeps the update processes free of bus decoding.
	assign wr_cfg = wr_commit && sel_cfg && lane0;
	assign wr_next = wr_commit && sel_next && lane0;
	assign wr_data = wr_commit && sel_data && lane0;
	assign wr_stat = wr_commit && sel_stat && lane0;
	assign wr_mask = wr_commit && sel_mask && lane0;
	// Any of the three board resets releases the lock; presetn is the full reset.
	assign func_clear = main_rail_por || standby_rail_por || hard_reset;

	assign lock_mode = (lockable_pin_r.alt == ALT_DISABLE_CTRL);
	assign irq_mode = (lockable_pin_r.alt == ALT_EDGE_IRQ);

	// The lock function overrides direction and polarity without touching the stored bits.
	assign eff_dir_in = lock_mode ? 1'b1 : lockable_pin_r.dir;
	assign eff_pol = lock_mode ? 1'b0 : lockable_pin_r.pol;
	assign pin_value = pin_in ^ eff_pol;

	pin_edge_detect #(
		.WIDTH(1)
	) u_edge (
		.pclk(pclk),
		.presetn(presetn),
		.level(pin_in),
		.any_edge(pin_edge)
	);

	// Both edges count; polarity inversion cannot change whether an edge occurred.
	assign edge_event = irq_mode && eff_dir_in && pin_edge && edge_armed_r;

	// The edge history starts at zero, so the first cycle after reset could report a false edge on a high pin.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			edge_armed_r <= 1'b0;
		end else begin
			edge_armed_r <= 1'b1;
		end
	end

	// Pin high in lock mode makes the disable register read-only.
	assign dis_write_try = wr_commit && sel_dis && lane0;
	assign dis_write_ok = dis_write_try && !(lock_mode && pin_in);
	assign drop_event = dis_write_try && lock_mode && pin_in;

	always_comb begin
		lockable_pin_nxt = lockable_pin_r;
		if (wr_cfg) begin
			lockable_pin_nxt.dir = wbyte[`CFG_DIR_BIT];
			lockable_pin_nxt.pol = wbyte[`CFG_POL_BIT];
			lockable_pin_nxt.odt = wbyte[`CFG_ODT_BIT];
			if (lockable_pin_r.alt != ALT_DISABLE_CTRL) begin
				lockable_pin_nxt.alt = alt_e'(wbyte[`CFG_ALT_MSB:`CFG_ALT_LSB]);
			end
		end
		lockable_pin_nxt.rsvd = 3'h0;
		if (func_clear) begin
			lockable_pin_nxt.alt = ALT_GPIO;
		end
		// The standby-rail reset reloads the whole register; the others clear only the function field.
		if (standby_rail_por) begin
			lockable_pin_nxt = cfg_s'(`LOCKABLE_PIN_RESET);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lockable_pin_r <= cfg_s'(`LOCKABLE_PIN_RESET);
		end else begin
			lockable_pin_r <= lockable_pin_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			next_port_pin_zero_r <= `NEXT_PORT_PIN_ZERO_RESET;
		end else if (standby_rail_por) begin
			next_port_pin_zero_r <= `NEXT_PORT_PIN_ZERO_RESET;
		end else if (wr_next) begin
			next_port_pin_zero_r <= wbyte;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_out_r <= 1'b0;
		end else if (wr_data) begin
			data_out_r <= wbyte[`DATA_OUT_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			device_disable_r <= DISABLE_W'(`DEVICE_DISABLE_RESET);
		end else if (dis_write_ok) begin
			device_disable_r <= wbyte[DISABLE_W-1:0];
		end
	end

	// A hardware set in the same cycle as a software clear wins, so no event is lost.
	always_comb begin
		stat_set = 8'h00;
		stat_set[`STAT_EDGE_BIT] = edge_event;
		stat_set[`STAT_DROP_BIT] = drop_event;
		stat_clr = 8'h00;
		if (wr_stat) begin
			stat_clr = wbyte & `STAT_MASK;
		end
		irq_status_nxt = ((irq_status_r & ~stat_clr) | stat_set) & `STAT_MASK;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status_r <= `IRQ_RESET;
		end else begin
			irq_status_r <= irq_status_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_r <= `IRQ_RESET;
		end else if (wr_mask) begin
			irq_mask_r <= wbyte & `STAT_MASK;
		end
	end

	// The interrupt is taken from the next status, so it rises with the status bit and still leaves a flop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_status_nxt & irq_mask_r);
		end
	end

	// Pin drive: open-drain only ever pulls low, push-pull drives both levels.
	always_comb begin
		pin_nxt.in = 1'b0;
		pin_nxt.out = 1'b0;
		pin_nxt.oe = 1'b0;
		if (eff_dir_in) begin
			pin_nxt.oe = 1'b0;
		end else if (lockable_pin_r.odt) begin
			pin_nxt.oe = !(data_out_r ^ eff_pol);
		end else begin
			pin_nxt.out = data_out_r ^ eff_pol;
			pin_nxt.oe = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_r <= '0;
		end else begin
			pin_r <= pin_nxt;
		end
	end

	assign lock_nxt = lock_mode && pin_in;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= 1'b0;
		end else begin
			lock_r <= lock_nxt;
		end
	end

	// Reads are decoded by index; an unaligned address reads zero like an unmapped one.
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		if (aligned) begin
			case (idx)
				IDX_W'(`LOCKABLE_PIN_IDX): begin
					rdata_nxt[7:0] = lockable_pin_r & `CFG_WRITABLE_MASK;
				end
				IDX_W'(`NEXT_PORT_PIN_ZERO_IDX): begin
					rdata_nxt[7:0] = next_port_pin_zero_r;
				end
				IDX_W'(`PIN_DATA_IDX): begin
					rdata_nxt[`DATA_OUT_BIT] = data_out_r;
					rdata_nxt[`DATA_IN_BIT] = pin_value;
					rdata_nxt[`DATA_LOCK_BIT] = lock_nxt;
				end
				IDX_W'(`DEVICE_DISABLE_IDX): begin
					rdata_nxt[DISABLE_W-1:0] = device_disable_r;
				end
				IDX_W'(`IRQ_STATUS_IDX): begin
					rdata_nxt[7:0] = irq_status_r;
				end
				IDX_W'(`IRQ_MASK_IDX): begin
					rdata_nxt[7:0] = irq_mask_r;
				end
				default: begin
					rdata_nxt = 32'h0000_0000;
				end
			endcase
		end
	end

	// Zero-wait slave: the answer is prepared in the setup cycle and stands for the access cycle.
	// Read data are forced to zero outside a read answer so stale values never reach the bus.
	always_comb begin
		rsp_nxt.ready = setup;
		rsp_nxt.slverr = setup && !mapped;
		rsp_nxt.rdata = 32'h0000_0000;
		if (setup && !pwrite) begin
			rsp_nxt.rdata = rdata_nxt;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_r <= '0;
		end else begin
			rsp_r <= rsp_nxt;
		end
	end

	assign prdata = rsp_r.rdata;
	assign pready = rsp_r.ready;
	assign pslverr = rsp_r.slverr;
	assign pin_out = pin_r.out;
	assign pin_oe = pin_r.oe;
	assign device_disable = device_disable_r;
	assign disable_write_lock_control = lock_r;
	assign irq = irq_r;
endmodule

`default_nettype wire

// File: src/gpio_pin_regs.svh
// Overview of operation
// - Configuration bit 0 sets direction: one means input, zero means output.
// - Configuration bit 1 inverts the pin value when one, passes it when zero.
// - Function field value 11 makes the pin an either-edge interrupt input when bit 0 selects input; with bit 0 zero it stays an output.
// - Function field value 01 makes the pin the disable-register write control input.
// - Function 00 is plain GPIO; code 10 selects nothing; bits 6 to 4 reserved.
// - In disable-control function the pin is a non-inverted input regardless of bits.
// - Once the function field holds 01, software writes to the field are ignored.
// - Main-rail, standby-rail power-on and hard resets clear the function field.
// - Disable-control active and pin high: disable register is read-only, writes discarded.
// - Disable-control active and pin low: disable register is readable and writable.
// - Configuration bit 7 selects open-drain when one, push-pull when zero.
`ifndef GPIO_PIN_REGS_SVH
`define GPIO_PIN_REGS_SVH

`define LOCKABLE_PIN_IDX 12'h03E
`define NEXT_PORT_PIN_ZERO_IDX 12'h03F
`define PIN_DATA_IDX 12'h040
`define DEVICE_DISABLE_IDX 12'h041
`define IRQ_STATUS_IDX 12'h042
`define IRQ_MASK_IDX 12'h043

`define LOCKABLE_PIN_RESET 8'h01
`define NEXT_PORT_PIN_ZERO_RESET 8'h01
`define DEVICE_DISABLE_RESET 8'h00
`define IRQ_RESET 8'h00

`define CFG_DIR_BIT 0
`define CFG_POL_BIT 1
`define CFG_ALT_LSB 2
`define CFG_ALT_MSB 3
`define CFG_ODT_BIT 7
`define CFG_WRITABLE_MASK 8'h8F

`define DATA_OUT_BIT 0
`define DATA_IN_BIT 1
`define DATA_LOCK_BIT 2

`define STAT_EDGE_BIT 0
`define STAT_DROP_BIT 1
`define STAT_MASK 8'h03

`define BYTE_ADDR_SHIFT 2

`endif

// File: src/gpio_pin_pkg.sv
package gpio_pin_pkg;

	typedef enum logic [1:0] {
		ALT_GPIO = 2'h0,
		ALT_DISABLE_CTRL = 2'h1,
		ALT_NONE = 2'h2,
		ALT_EDGE_IRQ = 2'h3
	} alt_e;

	typedef struct packed {
		logic odt;
		logic [2:0] rsvd;
		alt_e alt;
		logic pol;
		logic dir;
	} cfg_s;

	typedef struct packed {
		logic in;
		logic out;
		logic oe;
	} pin_s;

	typedef struct packed {
		logic ready;
		logic slverr;
		logic [31:0] rdata;
	} apb_rsp_s;

endpackage

// File: src/pin_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none

// Flags any change of a synchronous level; the previous value is one flop deep.
module pin_edge_detect #(
	parameter int WIDTH = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [WIDTH-1:0] level,
	output logic [WIDTH-1:0] any_edge
);
	logic [WIDTH-1:0] prev_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_r <= '0;
		end else begin
			prev_r <= level;
		end
	end

	assign any_edge = prev_r ^ level;
endmodule

`default_nettype wire

// File: dv/pin_board_model.sv
`timescale 1ns/1ps
`default_nettype none

// The board drives the pin weakly at all times, so the device always wins when it enables its driver.
module pin_board_model (
	input wire logic pin_out,
	input wire logic pin_oe,
	input wire logic drv_val,
	output logic pin_in
);
	assign pin_in = pin_oe ? pin_out : drv_val;
endmodule

`default_nettype wire

// File: dv/gpio_pin_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_regs.svh"

module gpio_pin_checker #(
	parameter int ADDR_W = 12,
	parameter int DISABLE_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic main_rail_por,
	input wire logic standby_rail_por,
	input wire logic hard_reset,
	input wire logic pin_in,
	input wire logic pin_oe,
	input wire logic [DISABLE_W-1:0] device_disable,
	input wire logic disable_write_lock_control
);
	localparam logic [ADDR_W-1:0] CFG = ADDR_W'(`LOCKABLE_PIN_IDX << `BYTE_ADDR_SHIFT);
	localparam logic [ADDR_W-1:0] DIS = ADDR_W'(`DEVICE_DISABLE_IDX << `BYTE_ADDR_SHIFT);
	logic commit_dis;
	logic any_rst;
	assign commit_dis = psel && penable && pready && pwrite && paddr == DIS && pstrb[0];
	assign any_rst = main_rail_por || standby_rail_por || hard_reset;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_ACCESS_ONE: assert property (psel && !penable |=> pready)
		else $error("no answer in the first access cycle");
	AST_PREADY_PULSE: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	AST_BAD_ADDR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr)
		else $error("unaligned access not refused");
	AST_RSVD_ZERO: assert property (pready && !pwrite && paddr == CFG
		|-> prdata[31:8] == 24'h0 && prdata[6:4] == 3'h0)
		else $error("reserved configuration bits read nonzero");
	AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside access");
	AST_LOCK_INPUT: assert property (disable_write_lock_control && !$past(any_rst) |-> !pin_oe)
		else $error("pin driven while in disable-control function");
	AST_LOCKED_DROP: assert property (commit_dis && disable_write_lock_control && pin_in
		&& $past(pin_in) && !$past(any_rst) |=> $stable(device_disable))
		else $error("disable register written while locked");
	AST_OPEN_WRITE: assert property (commit_dis && !pin_in |=> device_disable == $past(pwdata[DISABLE_W-1:0]))
		else $error("disable register write lost while open");
	AST_FUNC_CLEAR: assert property (any_rst |-> ##2 !disable_write_lock_control)
		else $error("lock survived a clearing reset");
endmodule

bind gpio_pin_with_disable_lock gpio_pin_checker #(.ADDR_W(ADDR_W), .DISABLE_W(DISABLE_W)) u_chk (.pclk(pclk),
	.presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .main_rail_por(main_rail_por),
	.standby_rail_por(standby_rail_por), .hard_reset(hard_reset), .pin_in(pin_in), .pin_oe(pin_oe),
	.device_disable(device_disable), .disable_write_lock_control(disable_write_lock_control));

`default_nettype wire

// File: dv/test_gpio_pin_with_disable_lock.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpio_pin_regs.svh"

module test_gpio_pin_with_disable_lock;
	import gpio_pin_pkg::*;
	localparam logic [11:0] CFG = `LOCKABLE_PIN_IDX << `BYTE_ADDR_SHIFT;
	localparam logic [11:0] NXT = `NEXT_PORT_PIN_ZERO_IDX << `BYTE_ADDR_SHIFT;
	localparam logic [11:0] DAT = `PIN_DATA_IDX << `BYTE_ADDR_SHIFT;
	localparam logic [11:0] DIS = `DEVICE_DISABLE_IDX << `BYTE_ADDR_SHIFT;
	localparam logic [11:0] STA = `IRQ_STATUS_IDX << `BYTE_ADDR_SHIFT;
	localparam logic [11:0] MSK = `IRQ_MASK_IDX << `BYTE_ADDR_SHIFT;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, drv_val = 1'b1, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [3:0] pstrb = 4'hF;
	logic [2:0] rsts = 3'h0;
	logic pready, pslverr, pin_in, pin_out, pin_oe, lock, irq;
	logic [7:0] ddis;
	int fails = 0, checks = 0, cyc = 0;

	always #20 pclk = ~pclk;

	gpio_pin_with_disable_lock dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.main_rail_por(rsts[0]), .standby_rail_por(rsts[1]), .hard_reset(rsts[2]), .pin_in(pin_in),
		.pin_out(pin_out), .pin_oe(pin_oe), .device_disable(ddis), .disable_write_lock_control(lock), .irq(irq));
	pin_board_model board (.pin_out(pin_out), .pin_oe(pin_oe), .drv_val(drv_val), .pin_in(pin_in));

	task complete_run();
		if (fails == 0 && checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, e);
		end
	endtask

	// The request is held until ready is sampled high; a hung slave is left to the cycle ceiling.
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdc(input logic [11:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	always @(posedge pclk) begin
		cyc++;
		if (cyc == 4000) begin
			fails++;
			complete_run();
		end
	end

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		rdc(CFG, 32'h01);
		rdc(NXT, 32'h01);
		rdc(DIS, 32'h00);
		rdc(STA, 32'h00);
		rdc(MSK, 32'h00);
		xfer(1'b1, CFG, 32'hF0);
		rdc(CFG, 32'h80);
		xfer(1'b1, DAT, 32'h01);
		repeat (2) @(posedge pclk);
		chk({31'h0, pin_oe}, 32'h0);
		rdc(DAT, 32'h03);
		xfer(1'b1, DAT, 32'h00);
		repeat (2) @(posedge pclk);
		chk({30'h0, pin_oe, pin_out}, 32'h2);
		xfer(1'b1, CFG, 32'h02);
		repeat (2) @(posedge pclk);
		chk({30'h0, pin_oe, pin_out}, 32'h3);
		rdc(DAT, 32'h00);
		xfer(1'b1, CFG, 32'h01);
		repeat (2) @(posedge pclk);
		chk({31'h0, pin_oe}, 32'h0);
		xfer(1'b1, MSK, 32'h03);
		// Code 10 must stay silent on a pin change; code 11 must flag it.
		for (int k = 2; k < 4; k++) begin
			xfer(1'b1, CFG, 32'(k * 4 + 1));
			drv_val <= ~drv_val;
			repeat (4) @(posedge pclk);
			rdc(STA, 32'(k == 3));
			chk({31'h0, irq}, 32'(k == 3));
		end
		xfer(1'b1, STA, 32'h01);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		xfer(1'b1, MSK, 32'h00);
		drv_val <= ~drv_val;
		repeat (4) @(posedge pclk);
		chk({31'h0, irq}, 32'h0);
		rdc(STA, 32'h01);
		xfer(1'b1, STA, 32'h01);
		xfer(1'b1, MSK, 32'h03);
		xfer(1'b1, CFG, 32'h06);
		drv_val <= 1'b1;
		repeat (3) @(posedge pclk);
		rdc(CFG, 32'h06);
		chk({31'h0, pin_oe}, 32'h0);
		rdc(DAT, 32'h06);
		chk({31'h0, lock}, 32'h1);
		xfer(1'b1, DIS, 32'h5A);
		rdc(DIS, 32'h00);
		rdc(STA, 32'h02);
		chk({31'h0, irq}, 32'h1);
		drv_val <= 1'b0;
		xfer(1'b1, DIS, 32'h5A);
		rdc(DIS, 32'h5A);
		chk({24'h0, ddis}, 32'h5A);
		xfer(1'b1, CFG, 32'h00);
		rdc(CFG, 32'h04);
		drv_val <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			xfer(1'b1, CFG, 32'h05);
			@(posedge pclk);
			rsts <= 3'h1 << k;
			@(posedge pclk);
			rsts <= 3'h0;
			repeat (2) @(posedge pclk);
			rdc(CFG, 32'h01);
		end
		xfer(1'b0, 12'h201, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		complete_run();
	end
endmodule

`default_nettype wire
